// ### common/irq_map_pkg.sv
package irq_map_pkg;

   // sizes
   localparam int NUM_SRC   = 9;
   localparam int NUM_VEC   = 34;
   localparam int VEC_W     = 6;
   localparam int WADDR_W   = 8;
   localparam int NUM_PER   = 8;
   localparam int IO_ADDR_W = 16;
   localparam int OFS_W     = 8;
   localparam int CNT_W     = 8;

   // fixed vectors and their program word addresses
   localparam logic [VEC_W-1:0]   VEC_RESET  = 6'h00;
   localparam logic [VEC_W-1:0]   VEC_NMI    = 6'h01;
   localparam logic [VEC_W-1:0]   VEC_VLM    = 6'h02;
   localparam logic [WADDR_W-1:0] ADDR_RESET = 8'h00;
   localparam logic [WADDR_W-1:0] ADDR_NMI   = 8'h02;
   localparam logic [WADDR_W-1:0] ADDR_VLM   = 8'h04;

   // interrupt sources, one flag and one enable bit each
   localparam int SRC_SCAN     = 0; // memory_scan_checker, non-maskable
   localparam int SRC_VLM      = 1; // supply_level_monitor_vector
   localparam int SRC_TA_OVF   = 2; // timer_a_unit overflow
   localparam int SRC_TB1_CAPT = 3; // timer_b_unit_one capture
   localparam int SRC_TB1_OVF  = 4; // timer_b_unit_one overflow
   localparam int SRC_TD_OVF   = 5; // timer_d_unit overflow
   localparam int SRC_SP1_RXC  = 6; // serial_port_one receive complete
   localparam int SRC_SP1_DRE  = 7; // serial_port_one data empty
   localparam int SRC_SP1_TXC  = 8; // serial_port_one transmit complete

   // vector of each source; both timer_b_unit_one sources share one
   localparam logic [VEC_W-1:0] SRC_VEC [NUM_SRC] = '{
      6'h01, 6'h02, 6'h09, 6'h0f, 6'h0f, 6'h10, 6'h1f, 6'h20, 6'h21};
   localparam logic [NUM_SRC-1:0] SRC_NMI_MASK = 9'h001;

   // peripheral register blocks
   localparam int PER_SCAN = 0;
   localparam int PER_SP0  = 1;
   localparam int PER_SP1  = 2;
   localparam int PER_TA   = 3;
   localparam int PER_TB0  = 4;
   localparam int PER_TB1  = 5;
   localparam int PER_TB2  = 6;
   localparam int PER_TD   = 7;
   localparam logic [IO_ADDR_W-1:0] PER_BASE [NUM_PER] = '{
      16'h0120, 16'h0800, 16'h0820, 16'h0a00,
      16'h0b00, 16'h0b10, 16'h0b20, 16'h0b80};
   localparam logic [IO_ADDR_W-1:0] PER_SPAN [NUM_PER] = '{
      16'h001f, 16'h001f, 16'h001f, 16'h00ff,
      16'h000f, 16'h000f, 16'h000f, 16'h007f};

   typedef struct packed {
      logic flag;
      logic enable;
      logic req;
   } src_state_type;

   typedef struct packed {
      logic [NUM_PER-1:0] sel;
      logic [OFS_W-1:0]   offset;
      logic               hit;
   } decode_state_type;

   typedef struct packed {
      logic [VEC_W-1:0]   vector;
      logic [WADDR_W-1:0] word_addr;
      logic               nmi;
   } vec_answer_type;

   typedef struct packed {
      logic               valid;
      vec_answer_type     ans;
      vec_answer_type     taken;
      logic [CNT_W-1:0]   take_count;
   } core_state_type;

   // reset values
   localparam src_state_type    SRC_STATE_RST  = '0;
   localparam decode_state_type DEC_STATE_RST  = '0;
   localparam core_state_type   CORE_STATE_RST = '0;

   // address falls inside a block
   function automatic logic in_window(input logic [IO_ADDR_W-1:0] addr,
                                      input logic [IO_ADDR_W-1:0] base,
                                      input logic [IO_ADDR_W-1:0] span);
      in_window = ((addr & ~span) == base);
   endfunction : in_window

   // two program words per vector slot
   function automatic logic [WADDR_W-1:0] vec_word_addr(input logic [VEC_W-1:0] vec);
      case (vec)
         VEC_RESET: vec_word_addr = ADDR_RESET;
         VEC_NMI:   vec_word_addr = ADDR_NMI;
         VEC_VLM:   vec_word_addr = ADDR_VLM;
         // whole vector kept, slots above 31 need its top bit
         default:   vec_word_addr = WADDR_W'({vec, 1'b0});
      endcase
   endfunction : vec_word_addr

endpackage : irq_map_pkg

// ### design/io_block_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module io_block_decoder
   import irq_map_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   input  wire logic                 io_strobe,
   input  wire logic [IO_ADDR_W-1:0] io_addr,
   output logic      [NUM_PER-1:0]   per_select,
   output logic      [OFS_W-1:0]     per_offset,
   output logic                      per_hit
);

   decode_state_type cur_q;
   decode_state_type nxt_d;

   // one-hot select and offset within the block
   always_comb begin
      nxt_d = DEC_STATE_RST;
      if (io_strobe) begin
         for (int p = 0; p < NUM_PER; p++) begin
            if (in_window(io_addr, PER_BASE[p], PER_SPAN[p])) begin
               nxt_d.sel[p]  = 1'b1;
               nxt_d.offset = OFS_W'(io_addr & PER_SPAN[p]);
            end
         end
         nxt_d.hit = |nxt_d.sel;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cur_q <= DEC_STATE_RST;
      end else begin
         cur_q <= nxt_d;
      end
   end

   assign per_select = cur_q.sel;
   assign per_offset = cur_q.offset;
   assign per_hit    = cur_q.hit;

endmodule : io_block_decoder
`default_nettype wire

// ### design/irq_request_and_vector_map.sv
`timescale 1ns/1ps
`default_nettype none
module irq_request_and_vector_map
   import irq_map_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   // condition pulses from the peripherals
   input  wire logic [NUM_SRC-1:0]   src_event,
   // flag clear pulses, one per source
   input  wire logic [NUM_SRC-1:0]   flag_clear,
   // enable register write: mask selects bits, data gives values
   input  wire logic [NUM_SRC-1:0]   enable_wr_mask,
   input  wire logic [NUM_SRC-1:0]   enable_wr_data,
   // global enable held by the core
   input  wire logic                 global_enable,
   // core takes the offered vector
   input  wire logic                 vector_take,
   // I/O space access
   input  wire logic                 io_strobe,
   input  wire logic [IO_ADDR_W-1:0] io_addr,
   // per-source state
   output logic      [NUM_SRC-1:0]   interrupt_flag_register,
   output logic      [NUM_SRC-1:0]   interrupt_enable_register,
   output logic      [NUM_SRC-1:0]   src_request,
   // per-vector requests
   output logic      [NUM_VEC-1:0]   vec_request,
   // offer to the core
   output logic                      irq_valid,
   output vec_answer_type            irq_answer,
   output vec_answer_type            taken_answer,
   output logic      [CNT_W-1:0]     take_count,
   // block decode
   output logic      [NUM_PER-1:0]   per_select,
   output logic      [OFS_W-1:0]     per_offset,
   output logic                      per_hit
);

   core_state_type cur_q;
   core_state_type nxt_d;

   logic [NUM_SRC-1:0] flag_w;
   logic [NUM_SRC-1:0] enable_w;
   logic [NUM_SRC-1:0] request_w;
   logic [NUM_SRC-1:0] vec_hits [NUM_VEC];
   logic [VEC_W-1:0]   pick_vec;
   logic               pick_any;

   // one cell per source: flag, enable and request gating
   for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
      irq_source_cell #(
         .NON_MASKABLE (SRC_NMI_MASK[s])
      ) u_cell (
         .ref_clk   (ref_clk),
         .rst       (rst),
         .event_in  (src_event[s]),
         .clear_in  (flag_clear[s]),
         .wr_en     (enable_wr_mask[s]),
         .wr_data   (enable_wr_data[s]),
         .global_en (global_enable),
         .flag      (flag_w[s]),
         .enable    (enable_w[s]),
         .request   (request_w[s])
      );
   end

   // fold the sources of each vector together
   for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
      for (genvar s = 0; s < NUM_SRC; s++) begin : g_hit
         // a source reaches only the vector its peripheral owns
         assign vec_hits[v][s] = (SRC_VEC[s] == VEC_W'(v)) & request_w[s];
      end
      if (v == 0) begin : g_reset_slot
         // the reset slot is never requested
         assign vec_request[v] = 1'b0;
      end else begin : g_live_slot
         assign vec_request[v] = |vec_hits[v];
      end
   end

   // lowest pending vector number wins
   always_comb begin
      pick_vec = VEC_RESET;
      pick_any = 1'b0;
      for (int v = NUM_VEC - 1; v > 0; v--) begin
         if (vec_request[v]) begin
            pick_vec = VEC_W'(v);
            pick_any = 1'b1;
         end
      end
   end

   // offer and take bookkeeping
   always_comb begin
      nxt_d = cur_q;
      nxt_d.valid = pick_any;
      // the fixed slots come out of the address function
      nxt_d.ans.vector    = pick_vec;
      nxt_d.ans.word_addr = vec_word_addr(pick_vec);
      nxt_d.ans.nmi       = (pick_vec == VEC_NMI);
      if (vector_take && cur_q.valid) begin
         nxt_d.taken      = cur_q.ans;
         nxt_d.take_count = cur_q.take_count + CNT_W'(1);
         // flags are left alone: taking the vector does not withdraw its request
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cur_q <= CORE_STATE_RST;
      end else begin
         cur_q <= nxt_d;
      end
   end

   // block decoder for the I/O space
   io_block_decoder u_decode (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .io_strobe  (io_strobe),
      .io_addr    (io_addr),
      .per_select (per_select),
      .per_offset (per_offset),
      .per_hit    (per_hit)
   );

   // outputs
   assign interrupt_flag_register   = flag_w;
   assign interrupt_enable_register = enable_w;
   assign src_request               = request_w;
   // offer lags the requests by one register stage
   assign irq_valid    = cur_q.valid;
   assign irq_answer   = cur_q.ans;
   assign taken_answer = cur_q.taken;
   assign take_count   = cur_q.take_count;

endmodule : irq_request_and_vector_map
`default_nettype wire

// ### design/irq_source_cell.sv
`timescale 1ns/1ps
`default_nettype none
module irq_source_cell
   import irq_map_pkg::*;
#(
   parameter bit NON_MASKABLE = 1'b0
)(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic event_in,
   input  wire logic clear_in,
   input  wire logic wr_en,
   input  wire logic wr_data,
   input  wire logic global_en,
   output logic      flag,
   output logic      enable,
   output logic      request
);

   src_state_type cur_q;
   src_state_type nxt_d;

   // flag, enable and registered request gated by the enable bit; the global enable gates the request at the output; a NON_MASKABLE cell skips both gates
   always_comb begin
      nxt_d = cur_q;
      // set beats a clear landing in the same cycle
      nxt_d.flag = event_in | (cur_q.flag & ~clear_in);
      if (wr_en) begin
         nxt_d.enable = wr_data;
      end
      // built from next values so a clear drops it in the same cycle as the flag
      nxt_d.req = nxt_d.flag & (nxt_d.enable | NON_MASKABLE);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cur_q <= SRC_STATE_RST;
      end else begin
         cur_q <= nxt_d;
      end
   end

   assign flag    = cur_q.flag;
   assign enable  = cur_q.enable;
   // global gate stays combinational so no stale request leaks
   assign request = cur_q.req & (global_en | NON_MASKABLE);

endmodule : irq_source_cell
`default_nettype wire

// ### sim/core_take_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_take_model (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       irq_valid,
   input  wire logic [1:0] lag,
   output logic            vector_take
);
   logic [1:0] wait_q = 2'h0;
   initial vector_take = 1'b0;
   // takes each offer once after it stood lag cycles; lag 3 never takes
   always @(negedge ref_clk) begin
      wait_q      <= (rst || !irq_valid) ? 2'h0 : wait_q + {1'b0, wait_q != 2'h3};
      vector_take <= !rst && irq_valid && lag != 2'h3 && wait_q == lag;
   end
endmodule : core_take_model
`default_nettype wire

// ### sim/irq_request_and_vector_map_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module irq_map_checker
   import irq_map_pkg::*;
(
   input wire logic                 ref_clk,
   input wire logic                 rst,
   input wire logic [NUM_SRC-1:0]   src_event,
   input wire logic [NUM_SRC-1:0]   flag_clear,
   input wire logic                 global_enable,
   input wire logic                 io_strobe,
   input wire logic [IO_ADDR_W-1:0] io_addr,
   input wire logic [NUM_SRC-1:0]   interrupt_flag_register,
   input wire logic [NUM_SRC-1:0]   interrupt_enable_register,
   input wire logic [NUM_SRC-1:0]   src_request,
   input wire logic [NUM_VEC-1:0]   vec_request,
   input wire logic                 irq_valid,
   input wire vec_answer_type       irq_answer,
   input wire logic [NUM_PER-1:0]   per_select,
   input wire logic [OFS_W-1:0]     per_offset,
   input wire logic                 per_hit
);
   // one domain, reset masks every check
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_flag_set; src_event != '0 |=> (interrupt_flag_register & $past(src_event)) == $past(src_event); endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag missed its event");
   // source 0 is non-maskable, so it skips both enables
   property p_gate; 1 |-> src_request == (interrupt_flag_register & (interrupt_enable_register | SRC_NMI_MASK)
      & ({NUM_SRC{global_enable}} | SRC_NMI_MASK)); endproperty
   a_gate: assert property (p_gate) else $error("request not flag and enables");
   property p_hold; 1 |=> ($past(interrupt_flag_register) & ~$past(flag_clear) & ~interrupt_flag_register) == '0;
   endproperty
   a_hold: assert property (p_hold) else $error("flag fell without a clear");
   property p_clear; (flag_clear & ~src_event) != '0
      |=> (interrupt_flag_register & $past(flag_clear) & ~$past(src_event)) == '0; endproperty
   a_clear: assert property (p_clear) else $error("flag outlived its clear");
   // vector 15 merges both timer_b_unit_one sources
   property p_vec; 1 |-> !vec_request[0] && vec_request[1] == src_request[SRC_SCAN]
      && vec_request[15] == (src_request[SRC_TB1_CAPT] | src_request[SRC_TB1_OVF]); endproperty
   a_vec: assert property (p_vec) else $error("vector request map wrong");
   property p_offer; 1 |=> irq_valid == ($past(vec_request) != '0); endproperty
   a_offer: assert property (p_offer) else $error("offer does not follow requests");
   property p_addr; irq_valid |-> irq_answer.word_addr == WADDR_W'({irq_answer.vector, 1'b0})
      && irq_answer.nmi == (irq_answer.vector == VEC_NMI); endproperty
   a_addr: assert property (p_addr) else $error("vector word address wrong");
   property p_dec; io_strobe && io_addr[15:4] == 12'h0b1
      |=> per_hit && per_select == 8'h20 && per_offset == OFS_W'($past(io_addr) & 16'h000f); endproperty
   a_dec: assert property (p_dec) else $error("timer b one block not decoded");
endmodule : irq_map_checker

bind irq_request_and_vector_map irq_map_checker irq_map_checker_inst (.ref_clk, .rst, .src_event, .flag_clear,
   .global_enable, .io_strobe, .io_addr, .interrupt_flag_register, .interrupt_enable_register,
   .src_request, .vec_request, .irq_valid, .irq_answer, .per_select, .per_offset, .per_hit);
`default_nettype wire

// ### sim/irq_request_and_vector_map_test.sv
`timescale 1ns/1ps
`default_nettype none
module irq_request_and_vector_map_test;
   import irq_map_pkg::*;
   logic                 ref_clk = 1'b1;
   logic                 rst = 1'b1;
   logic                 global_enable = 1'b0;
   logic                 io_strobe = 1'b0;
   logic [NUM_SRC-1:0]   src_event = '0, flag_clear = '0, enable_wr_mask = '0, enable_wr_data = '0;
   logic [IO_ADDR_W-1:0] io_addr = '0;
   logic [1:0]           lag = 2'h3;
   logic                 vector_take, irq_valid, per_hit;
   logic [NUM_SRC-1:0]   interrupt_flag_register, interrupt_enable_register, src_request;
   logic [NUM_VEC-1:0]   vec_request;
   vec_answer_type       irq_answer, taken_answer;
   logic [CNT_W-1:0]     take_count;
   logic [NUM_PER-1:0]   per_select;
   logic [OFS_W-1:0]     per_offset;
   int                   err_count = 0, tests_run = 0, cycles = 0;

   // 40 MHz, starts high so inputs settle before the first rising edge
   always #12.5 ref_clk = ~ref_clk;

   irq_request_and_vector_map irq_request_and_vector_map_inst (.ref_clk, .rst, .src_event, .flag_clear,
      .enable_wr_mask, .enable_wr_data, .global_enable, .vector_take, .io_strobe, .io_addr,
      .interrupt_flag_register, .interrupt_enable_register, .src_request, .vec_request, .irq_valid,
      .irq_answer, .taken_answer, .take_count, .per_select, .per_offset, .per_hit);
   core_take_model core_take_model_inst (.ref_clk, .rst, .irq_valid, .lag, .vector_take);

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // inputs change on the falling edge only, then one rising edge passes
   task automatic drive(input logic [NUM_SRC-1:0] ev, clr, wm, wd);
      src_event = ev;
      flag_clear = clr;
      enable_wr_mask = wm;
      enable_wr_data = wd;
      @(negedge ref_clk);
   endtask : drive

   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   task automatic t_masked;
      global_enable = 1'b1;
      drive(9'h004, '0, '0, '0);
      chk(40'(interrupt_flag_register), 40'h004);
      chk(40'(src_request), 40'h0);
      drive('0, '0, 9'h004, 9'h004);
      chk(40'(interrupt_enable_register), 40'h004);
      chk(40'(src_request), 40'h004);
      chk(40'(vec_request), 40'h200);
      drive('0, 9'h004, '0, '0);
      chk(40'({interrupt_flag_register, src_request}), 40'h0);
      $display("masked flag test done");
   endtask : t_masked

   task automatic t_global;
      global_enable = 1'b0;
      drive('0, '0, 9'h1ff, 9'h1ff);
      chk(40'(interrupt_enable_register), 40'h1ff);
      drive(9'h006, '0, '0, '0);
      chk(40'(src_request), 40'h0);
      drive(9'h001, '0, '0, '0);
      chk(40'(src_request), 40'h001);
      drive('0, '0, '0, '0);
      chk(40'({irq_valid, irq_answer}), 40'({1'b1, 6'h01, 8'h02, 1'b1}));
      global_enable = 1'b1;
      drive('0, '0, '0, '0);
      chk(40'(src_request), 40'h007);
      drive('0, 9'h1ff, '0, '0);
      $display("global enable test done");
   endtask : t_global

   task automatic t_hold;
      lag = 2'h0;
      drive(9'h002, '0, '0, '0);
      drive('0, '0, '0, '0);
      repeat (3) @(negedge ref_clk);
      chk(40'(taken_answer), 40'({6'h02, 8'h04, 1'b0}));
      chk(40'(take_count), 40'h01);
      chk(40'({src_request, irq_valid}), 40'({9'h002, 1'b1}));
      drive(9'h002, 9'h002, '0, '0);
      chk(40'(interrupt_flag_register), 40'h002);
      drive('0, 9'h002, '0, '0);
      chk(40'({interrupt_flag_register, src_request}), 40'h0);
      lag = 2'h3;
      $display("hold and clear test done");
   endtask : t_hold

   task automatic t_vectors;
      logic [VEC_W-1:0] vec_of [NUM_SRC] = '{6'h01, 6'h02, 6'h09, 6'h0f, 6'h0f, 6'h10, 6'h1f, 6'h20, 6'h21};
      for (int i = 0; i < NUM_SRC; i++) begin
         drive(9'(1 << i), '0, '0, '0);
         chk(40'(vec_request), 40'(1) << vec_of[i]);
         drive('0, 9'(1 << i), '0, '0);
         chk(40'({irq_valid, irq_answer}), 40'({1'b1, vec_of[i], 8'({vec_of[i], 1'b0}), i == 0}));
      end
      $display("vector map test done");
   endtask : t_vectors

   // address, select, offset; the last two sit in unmapped gaps
   task automatic t_decode;
      logic [31:0] tbl [11] = '{32'h0120_01_00, 32'h013f_01_1f, 32'h0800_02_00, 32'h0835_04_15,
         32'h0a7e_08_7e, 32'h0b00_10_00, 32'h0b13_20_03, 32'h0b2f_40_0f, 32'h0bff_80_7f,
         32'h0900_00_00, 32'h0b30_00_00};
      io_strobe = 1'b1;
      foreach (tbl[i]) begin
         io_addr = tbl[i][31:16];
         @(negedge ref_clk);
         chk(40'({per_select, per_offset, per_hit}), 40'({tbl[i][15:0], tbl[i][15:8] != 8'h00}));
      end
      io_strobe = 1'b0;
      @(negedge ref_clk);
      chk(40'({per_select, per_offset, per_hit}), 40'h0);
      $display("address decode test done");
   endtask : t_decode

   // a hang counts as a mismatch
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      chk(40'({interrupt_flag_register, interrupt_enable_register, src_request, irq_valid, take_count}), 40'h0);
      t_masked();
      t_global();
      t_hold();
      t_vectors();
      t_decode();
      tally_and_finish();
   end
endmodule : irq_request_and_vector_map_test
`default_nettype wire
